// >>> inc/plim_consts.svh
// constants for the image pair manager: widths, table size, timing and codes
// assumes a 100 MHz core clock; included by plim_pkg and by the rtl and sim files
`ifndef PLIM_CONSTS_SVH
`define PLIM_CONSTS_SVH
// Summary of operation
// - pair key is local id, remote id, type
// - peer issues PRLI only after port login
// - failed establish leaves other pairs untouched
// - modifying PRLI names the exact pair
// - PRLI on established pair keeps pair
// - changed parameters abort open exchanges with ABTS
// - originator establishes after setup and LS_ACC
// - responder establishes after setup and sent LS_ACC
// - PRLI with link error never establishes
// - unlogged PRLI gets LOGO or login-required reject
// - reject on established pair keeps pair
// - peer retries busy, reject, silence, bounded
// - erroneous reply gives unknown, table unchanged
// - establish bit selects binding or informative
// - binding pair refuses unestablished paths
// - PRLO frees only the named pair
// - removed pair neither sends nor accepts units
// - PRLO for missing pair still accepted
// - PRLO originator removes only on LS_ACC
// - PRLO responder removes after sending LS_ACC
// - executed PRLO aborts pair exchanges by ABTS
// - stray traffic still acknowledged normally
`define PLIM_ID_W 24
`define PLIM_TYPE_W 8
`define PLIM_PARM_W 8
`define PLIM_TBL_DEPTH 4
`define PLIM_IDX_W 2
`define PLIM_CNT_W 8
`define PLIM_CLK_NS 10
`define PLIM_SETUP_NS 40
`define PLIM_SETUP_CYC ((`PLIM_SETUP_NS + `PLIM_CLK_NS - 1) / `PLIM_CLK_NS)
`define PLIM_RSP_TMO_NS 2000
`define PLIM_RSP_TMO_CYC (`PLIM_RSP_TMO_NS / `PLIM_CLK_NS)
`define PLIM_RETRY_MAX 3
`define PLIM_RSN_NONE 8'h00
`define PLIM_RSN_UNABLE 8'h01
`define PLIM_RSN_BUSY 8'h02
`define PLIM_EXP_NONE 8'h00
`define PLIM_EXP_LOGIN 8'h01
`define PLIM_EXP_FULL 8'h02
`endif

// >>> inc/plim_pkg.sv
// types and message helpers shared by both ends of the image pair link
// assumes plim_consts.svh on the include path
`include "plim_consts.svh"
package plim_pkg;
  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_PRLI = 4'h1, OP_PRLO = 4'h2, OP_LS_ACC = 4'h3,
    OP_LS_RJT = 4'h4, OP_LOGO = 4'h5, OP_P_BSY = 4'h6, OP_F_BSY = 4'h7,
    OP_P_RJT = 4'h8, OP_F_RJT = 4'h9, OP_DATA = 4'ha, OP_ACK = 4'hb,
    OP_ABTS = 4'hc
  } plim_op_t;
  typedef enum logic [1:0] {
    RES_OK = 2'h0, RES_REJ = 2'h1, RES_UNK = 2'h2, RES_REFUSED = 2'h3
  } plim_res_t;
  typedef logic [`PLIM_IDX_W-1:0] plim_idx_t;
  typedef logic [`PLIM_CNT_W-1:0] plim_cnt_t;
  typedef struct packed {
    logic [`PLIM_ID_W-1:0] loc;
    logic [`PLIM_ID_W-1:0] rem;
    logic [`PLIM_TYPE_W-1:0] typ;
  } plim_key_t;
  typedef struct packed {
    plim_op_t op;
    logic [`PLIM_ID_W-1:0] d_id;
    logic [`PLIM_ID_W-1:0] s_id;
    logic [`PLIM_TYPE_W-1:0] typ;
    logic est_req;
    logic [`PLIM_PARM_W-1:0] parm;
    logic lerr;
    logic [7:0] rsn;
    logic [7:0] expl;
  } plim_msg_t;

  function automatic logic plim_is_reply(input plim_op_t op);
    return (op == OP_LS_ACC) || (op == OP_LS_RJT) || (op == OP_LOGO) ||
           (op == OP_P_BSY) || (op == OP_F_BSY) || (op == OP_P_RJT) ||
           (op == OP_F_RJT) || (op == OP_ACK);
  endfunction

  function automatic plim_msg_t plim_mk(input plim_op_t op, input plim_key_t k,
                                        input logic est, input logic [7:0] parm,
                                        input logic [7:0] rsn, input logic [7:0] expl);
    plim_msg_t m;
    m = '0;
    m.op = op;
    m.d_id = k.rem;
    m.s_id = k.loc;
    m.typ = k.typ;
    m.est_req = est;
    m.parm = parm;
    m.rsn = rsn;
    m.expl = expl;
    return m;
  endfunction
endpackage

// >>> inc/plim_if.sv
// link between the managed port and its remote peer, one message per valid cycle
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface plim_if;
  import plim_pkg::*;
  logic p2d_vld;
  plim_msg_t p2d_msg;
  logic d2p_vld;
  plim_msg_t d2p_msg;
  modport port (input p2d_vld, input p2d_msg, output d2p_vld, output d2p_msg);
  modport peer (output p2d_vld, output p2d_msg, input d2p_vld, input d2p_msg);
endinterface
`default_nettype wire

// >>> rtl/plim_port.sv
// managed port end: image pair table, PRLI/PRLO responder and originator
// assumes the peer on plim_if shares CORE_CLK_I and sends one message at a time
`timescale 1ns/1ps
`default_nettype none
`include "plim_consts.svh"
module plim_port
  import plim_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  plim_if.port LINK,
  input wire logic LOGIN_OK_I,
  input wire logic NOLOGIN_LOGO_I,
  input wire logic CMD_VLD_I,
  input wire plim_op_t CMD_OP_I,
  input wire plim_key_t CMD_KEY_I,
  input wire logic CMD_EST_I,
  input wire logic [`PLIM_PARM_W-1:0] CMD_PARM_I,
  output logic CMD_RDY_O,
  output logic CMD_DONE_O,
  output plim_res_t CMD_RES_O,
  input wire logic TX_VLD_I,
  input wire plim_key_t TX_KEY_I,
  output logic TX_SENT_O,
  output logic TX_BLK_O,
  output logic RX_IU_O,
  output logic RX_STRAY_O,
  output plim_key_t EVT_KEY_O,
  output logic [`PLIM_TBL_DEPTH-1:0] EST_O
);
  localparam int D = `PLIM_TBL_DEPTH;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_SETUP = 3'h1, S_REPLY = 3'h2, S_COMMIT = 3'h3,
    S_ABTS = 3'h4, S_WAIT = 3'h5
  } plim_st_t;

  function automatic plim_idx_t first_idx(input logic [`PLIM_TBL_DEPTH-1:0] v);
    plim_idx_t r;
    r = '0;
    for (int i = `PLIM_TBL_DEPTH - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = plim_idx_t'(i);
      end
    end
    return r;
  endfunction

  // ****************************************
  // image pair table
  // ****************************************
  logic [D-1:0] est_ff;
  plim_key_t key_ff [D];
  logic [`PLIM_PARM_W-1:0] parm_ff [D];

  plim_st_t state_ff, nxt_state;
  plim_key_t cur_key_ff, nxt_key;
  plim_idx_t cur_idx_ff, nxt_idx;
  plim_op_t cur_op_ff, nxt_op;
  logic cur_est_ff, nxt_est;
  logic [`PLIM_PARM_W-1:0] cur_parm_ff, nxt_parm;
  logic cur_hit_ff, nxt_hit;
  logic orig_ff, nxt_orig;
  logic abts_ff, nxt_abts;
  plim_cnt_t cnt_ff, nxt_cnt;
  logic tx_vld_ff, nxt_tx_vld;
  plim_msg_t tx_msg_ff, nxt_tx_msg;
  logic done_ff, nxt_done;
  plim_res_t res_ff, nxt_res;
  logic sent_ff, nxt_sent;
  logic blk_ff, nxt_blk;
  logic rx_iu_ff, nxt_rx_iu;
  logic stray_ff, nxt_stray;
  plim_key_t evt_key_ff, nxt_evt_key;

  wire logic rx_vld;
  plim_msg_t rx;
  plim_key_t rx_key;
  plim_key_t look_key;
  logic [D-1:0] hit_vec;
  logic [D-1:0] free_vec;
  wire logic hit;
  wire logic free_any;
  plim_idx_t hit_idx;
  plim_idx_t free_idx;
  wire logic commit;
  wire logic parm_chg;

  assign rx_vld = LINK.p2d_vld;
  assign rx = LINK.p2d_msg;
  // incoming requests are seen from our side: their destination is our local id
  assign rx_key = '{loc: rx.d_id, rem: rx.s_id, typ: rx.typ};
  assign look_key = (state_ff != S_IDLE) ? cur_key_ff :
                    rx_vld ? rx_key : CMD_VLD_I ? CMD_KEY_I : TX_KEY_I;

  genvar g;
  generate
    for (g = 0; g < D; g++) begin : g_tbl
      assign hit_vec[g] = est_ff[g] && (key_ff[g] == look_key);
      assign free_vec[g] = !est_ff[g];
      // only the addressed entry is ever written, the rest hold
      always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
          est_ff[g] <= 1'b0;
          key_ff[g] <= '0;
          parm_ff[g] <= '0;
        end else if (commit && cur_idx_ff == plim_idx_t'(g)) begin
          if (cur_op_ff == OP_PRLO && cur_hit_ff) begin
            est_ff[g] <= 1'b0;
          end else if (cur_op_ff == OP_PRLI && cur_est_ff) begin
            est_ff[g] <= 1'b1;
            key_ff[g] <= cur_key_ff;
            parm_ff[g] <= cur_parm_ff;
          end
        end
      end
    end
  endgenerate

  assign hit = |hit_vec;
  assign free_any = |free_vec;
  assign hit_idx = first_idx(hit_vec);
  assign free_idx = first_idx(free_vec);
  assign commit = (state_ff == S_COMMIT);
  assign parm_chg = hit && (parm_ff[hit_idx] != (rx_vld ? rx.parm : CMD_PARM_I));

  // ****************************************
  // control sequence
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_key = cur_key_ff;
    nxt_idx = cur_idx_ff;
    nxt_op = cur_op_ff;
    nxt_est = cur_est_ff;
    nxt_parm = cur_parm_ff;
    nxt_hit = cur_hit_ff;
    nxt_orig = orig_ff;
    nxt_abts = abts_ff;
    nxt_cnt = cnt_ff;
    nxt_tx_vld = 1'b0;
    nxt_tx_msg = tx_msg_ff;
    nxt_done = 1'b0;
    nxt_res = res_ff;
    nxt_sent = 1'b0;
    nxt_blk = 1'b0;
    nxt_rx_iu = 1'b0;
    nxt_stray = 1'b0;
    nxt_evt_key = evt_key_ff;
    case (state_ff)
      S_IDLE: begin
        nxt_idx = hit ? hit_idx : free_idx;
        nxt_hit = hit;
        if (rx_vld) begin
          nxt_key = rx_key;
          nxt_orig = 1'b0;
          nxt_op = rx.op;
          nxt_est = rx.est_req;
          nxt_parm = rx.parm;
          if (rx.op == OP_PRLI && !rx.lerr) begin
            if (!LOGIN_OK_I) begin
              nxt_tx_vld = 1'b1;
              nxt_tx_msg = NOLOGIN_LOGO_I ?
                plim_mk(OP_LOGO, rx_key, 1'b0, '0, `PLIM_RSN_NONE, `PLIM_EXP_NONE) :
                plim_mk(OP_LS_RJT, rx_key, 1'b0, '0, `PLIM_RSN_UNABLE, `PLIM_EXP_LOGIN);
            end else if (!hit && rx.est_req && !free_any) begin
              nxt_tx_vld = 1'b1;
              nxt_tx_msg = plim_mk(OP_LS_RJT, rx_key, 1'b0, '0, `PLIM_RSN_UNABLE,
                                   `PLIM_EXP_FULL);
            end else begin
              // existing pair stays live while the request is worked
              nxt_abts = rx.est_req && parm_chg;
              nxt_cnt = plim_cnt_t'(`PLIM_SETUP_CYC - 1);
              nxt_state = S_SETUP;
            end
          end else if (rx.op == OP_PRLO && !rx.lerr) begin
            nxt_abts = hit;
            nxt_state = S_REPLY;
          end else if (rx.op == OP_DATA) begin
            nxt_tx_vld = 1'b1;
            nxt_tx_msg = plim_mk(OP_ACK, rx_key, 1'b0, '0, `PLIM_RSN_NONE, `PLIM_EXP_NONE);
            nxt_rx_iu = hit;
            nxt_stray = !hit;
            nxt_evt_key = rx_key;
          end
        end else if (CMD_VLD_I && !done_ff) begin
          nxt_key = CMD_KEY_I;
          nxt_orig = 1'b1;
          nxt_op = CMD_OP_I;
          nxt_est = CMD_EST_I;
          nxt_parm = CMD_PARM_I;
          nxt_abts = (CMD_OP_I == OP_PRLO) ? hit : (CMD_EST_I && parm_chg);
          if (CMD_OP_I == OP_PRLI && !(CMD_EST_I && !hit && !free_any)) begin
            nxt_cnt = plim_cnt_t'(`PLIM_SETUP_CYC - 1);
            nxt_state = S_SETUP;
          end else if (CMD_OP_I == OP_PRLO) begin
            nxt_tx_vld = 1'b1;
            nxt_tx_msg = plim_mk(OP_PRLO, CMD_KEY_I, 1'b0, '0, `PLIM_RSN_NONE,
                                 `PLIM_EXP_NONE);
            nxt_cnt = plim_cnt_t'(`PLIM_RSP_TMO_CYC);
            nxt_state = S_WAIT;
          end else begin
            nxt_done = 1'b1;
            nxt_res = RES_REJ;
          end
        end else if (TX_VLD_I && !sent_ff && !blk_ff) begin
          nxt_evt_key = TX_KEY_I;
          if (hit) begin
            nxt_tx_vld = 1'b1;
            nxt_tx_msg = plim_mk(OP_DATA, TX_KEY_I, 1'b0, '0, `PLIM_RSN_NONE,
                                 `PLIM_EXP_NONE);
            nxt_sent = 1'b1;
          end else begin
            nxt_blk = 1'b1;
          end
        end
      end
      S_SETUP: begin
        if (cnt_ff != '0) begin
          nxt_cnt = cnt_ff - plim_cnt_t'(1);
        end else if (orig_ff) begin
          nxt_tx_vld = 1'b1;
          nxt_tx_msg = plim_mk(OP_PRLI, cur_key_ff, cur_est_ff, cur_parm_ff,
                               `PLIM_RSN_NONE, `PLIM_EXP_NONE);
          nxt_cnt = plim_cnt_t'(`PLIM_RSP_TMO_CYC);
          nxt_state = S_WAIT;
        end else begin
          nxt_state = S_REPLY;
        end
      end
      S_REPLY: begin
        nxt_tx_vld = 1'b1;
        nxt_tx_msg = plim_mk(OP_LS_ACC, cur_key_ff, cur_est_ff, cur_parm_ff,
                             `PLIM_RSN_NONE, `PLIM_EXP_NONE);
        nxt_state = S_COMMIT;
      end
      S_COMMIT: begin
        nxt_done = orig_ff;
        nxt_res = RES_OK;
        nxt_state = abts_ff ? S_ABTS : S_IDLE;
      end
      S_ABTS: begin
        nxt_tx_vld = 1'b1;
        nxt_tx_msg = plim_mk(OP_ABTS, cur_key_ff, 1'b0, '0, `PLIM_RSN_NONE, `PLIM_EXP_NONE);
        nxt_state = S_IDLE;
      end
      S_WAIT: begin
        if (rx_vld && plim_is_reply(rx.op)) begin
          if (rx.lerr) begin
            nxt_done = 1'b1;
            nxt_res = RES_UNK;
            nxt_state = S_IDLE;
          end else if (rx.op == OP_LS_ACC) begin
            nxt_state = S_COMMIT;
          end else begin
            nxt_done = 1'b1;
            nxt_res = RES_REJ;
            nxt_state = S_IDLE;
          end
        end else if (cnt_ff == '0) begin
          nxt_done = 1'b1;
          nxt_res = RES_UNK;
          nxt_state = S_IDLE;
        end else begin
          nxt_cnt = cnt_ff - plim_cnt_t'(1);
        end
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_ff <= S_IDLE;
      cur_key_ff <= '0;
      cur_idx_ff <= '0;
      cur_op_ff <= OP_NONE;
      cur_est_ff <= 1'b0;
      cur_parm_ff <= '0;
      cur_hit_ff <= 1'b0;
      orig_ff <= 1'b0;
      abts_ff <= 1'b0;
      cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cur_key_ff <= nxt_key;
      cur_idx_ff <= nxt_idx;
      cur_op_ff <= nxt_op;
      cur_est_ff <= nxt_est;
      cur_parm_ff <= nxt_parm;
      cur_hit_ff <= nxt_hit;
      orig_ff <= nxt_orig;
      abts_ff <= nxt_abts;
      cnt_ff <= nxt_cnt;
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      tx_vld_ff <= 1'b0;
      tx_msg_ff <= '0;
      done_ff <= 1'b0;
      res_ff <= RES_OK;
      sent_ff <= 1'b0;
      blk_ff <= 1'b0;
      rx_iu_ff <= 1'b0;
      stray_ff <= 1'b0;
      evt_key_ff <= '0;
      CMD_RDY_O <= 1'b0;
    end else begin
      tx_vld_ff <= nxt_tx_vld;
      tx_msg_ff <= nxt_tx_msg;
      done_ff <= nxt_done;
      res_ff <= nxt_res;
      sent_ff <= nxt_sent;
      blk_ff <= nxt_blk;
      rx_iu_ff <= nxt_rx_iu;
      stray_ff <= nxt_stray;
      evt_key_ff <= nxt_evt_key;
      CMD_RDY_O <= (nxt_state == S_IDLE);
    end
  end

  assign LINK.d2p_vld = tx_vld_ff;
  assign LINK.d2p_msg = tx_msg_ff;
  assign CMD_DONE_O = done_ff;
  assign CMD_RES_O = res_ff;
  assign TX_SENT_O = sent_ff;
  assign TX_BLK_O = blk_ff;
  assign RX_IU_O = rx_iu_ff;
  assign RX_STRAY_O = stray_ff;
  assign EVT_KEY_O = evt_key_ff;
  assign EST_O = est_ff;
endmodule
`default_nettype wire

// >>> rtl/plim_peer.sv
// remote peer end: issues PRLI/PRLO/data with bounded retry, answers requests
// assumes the managed port on plim_if shares CORE_CLK_I
`timescale 1ns/1ps
`default_nettype none
`include "plim_consts.svh"
module plim_peer
  import plim_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  plim_if.peer LINK,
  input wire logic LOGIN_I,
  input wire logic CMD_VLD_I,
  input wire plim_op_t CMD_OP_I,
  input wire plim_key_t CMD_KEY_I,
  input wire logic CMD_EST_I,
  input wire logic [`PLIM_PARM_W-1:0] CMD_PARM_I,
  output logic CMD_RDY_O,
  output logic CMD_DONE_O,
  output plim_res_t CMD_RES_O,
  output logic RX_IU_O,
  output logic RX_ABTS_O
);
  typedef enum logic {Q_IDLE = 1'b0, Q_WAIT = 1'b1} plim_pst_t;

  plim_pst_t state_ff, nxt_state;
  plim_cnt_t cnt_ff, nxt_cnt;
  logic [1:0] tries_ff, nxt_tries;
  logic tx_vld_ff, nxt_tx_vld;
  plim_msg_t tx_msg_ff, nxt_tx_msg;
  logic done_ff, nxt_done;
  plim_res_t res_ff, nxt_res;
  logic rx_iu_ff, nxt_rx_iu;
  logic abts_ff, nxt_abts;

  wire logic rx_vld;
  plim_msg_t rx;
  plim_key_t rx_key;
  wire logic rsp;
  wire logic can_retry;
  wire logic hard_rej;

  assign rx_vld = LINK.d2p_vld;
  assign rx = LINK.d2p_msg;
  assign rx_key = '{loc: rx.d_id, rem: rx.s_id, typ: rx.typ};
  assign rsp = rx_vld && plim_is_reply(rx.op);
  assign can_retry = (tries_ff < 2'(`PLIM_RETRY_MAX));
  // OP_LOGO without a link error is never retried; for OP_LS_RJT the reason code decides whether another try is worth it
  assign hard_rej = (rx.op == OP_LOGO) ||
                    (rx.op == OP_LS_RJT && rx.rsn == `PLIM_RSN_UNABLE);

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_tries = tries_ff;
    nxt_tx_vld = 1'b0;
    nxt_tx_msg = tx_msg_ff;
    nxt_done = 1'b0;
    nxt_res = res_ff;
    nxt_rx_iu = 1'b0;
    nxt_abts = 1'b0;
    case (state_ff)
      Q_IDLE: begin
        if (rx_vld) begin
          if ((rx.op == OP_PRLI || rx.op == OP_PRLO) && !rx.lerr) begin
            nxt_tx_vld = 1'b1;
            nxt_tx_msg = plim_mk(OP_LS_ACC, rx_key, rx.est_req, rx.parm,
                                 `PLIM_RSN_NONE, `PLIM_EXP_NONE);
          end else if (rx.op == OP_DATA) begin
            nxt_tx_vld = 1'b1;
            nxt_tx_msg = plim_mk(OP_ACK, rx_key, 1'b0, '0, `PLIM_RSN_NONE, `PLIM_EXP_NONE);
            nxt_rx_iu = 1'b1;
          end else if (rx.op == OP_ABTS) begin
            nxt_abts = 1'b1;
          end
        end else if (CMD_VLD_I && !done_ff) begin
          if (CMD_OP_I == OP_PRLI && !LOGIN_I) begin
            nxt_done = 1'b1;
            nxt_res = RES_REFUSED;
          end else begin
            nxt_tx_vld = 1'b1;
            nxt_tx_msg = plim_mk(CMD_OP_I, CMD_KEY_I, CMD_EST_I, CMD_PARM_I,
                                 `PLIM_RSN_NONE, `PLIM_EXP_NONE);
            nxt_tries = '0;
            nxt_cnt = plim_cnt_t'(`PLIM_RSP_TMO_CYC);
            nxt_state = Q_WAIT;
          end
        end
      end
      Q_WAIT: begin
        if (rsp && !rx.lerr && (rx.op == OP_LS_ACC || rx.op == OP_ACK)) begin
          nxt_done = 1'b1;
          nxt_res = RES_OK;
          nxt_state = Q_IDLE;
        end else if (rsp && !rx.lerr && hard_rej) begin
          nxt_done = 1'b1;
          nxt_res = RES_REJ;
          nxt_state = Q_IDLE;
        end else if (rsp || cnt_ff == '0) begin
          if (can_retry) begin
            nxt_tx_vld = 1'b1;
            nxt_tries = tries_ff + 2'h1;
            nxt_cnt = plim_cnt_t'(`PLIM_RSP_TMO_CYC);
          end else begin
            nxt_done = 1'b1;
            nxt_res = (rsp && !rx.lerr) ? RES_REJ : RES_UNK;
            nxt_state = Q_IDLE;
          end
        end else begin
          nxt_cnt = cnt_ff - plim_cnt_t'(1);
        end
      end
      default: begin
        nxt_state = Q_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_ff <= Q_IDLE;
      cnt_ff <= '0;
      tries_ff <= '0;
      tx_vld_ff <= 1'b0;
      tx_msg_ff <= '0;
      done_ff <= 1'b0;
      res_ff <= RES_OK;
      rx_iu_ff <= 1'b0;
      abts_ff <= 1'b0;
      CMD_RDY_O <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      tries_ff <= nxt_tries;
      tx_vld_ff <= nxt_tx_vld;
      tx_msg_ff <= nxt_tx_msg;
      done_ff <= nxt_done;
      res_ff <= nxt_res;
      rx_iu_ff <= nxt_rx_iu;
      abts_ff <= nxt_abts;
      CMD_RDY_O <= (nxt_state == Q_IDLE);
    end
  end

  assign LINK.p2d_vld = tx_vld_ff;
  assign LINK.p2d_msg = tx_msg_ff;
  assign CMD_DONE_O = done_ff;
  assign CMD_RES_O = res_ff;
  assign RX_IU_O = rx_iu_ff;
  assign RX_ABTS_O = abts_ff;
endmodule
`default_nettype wire

// >>> sim/plim_link_chk.sv
// checker on the link joining the port and peer ends
// assumes plim_if signals, one clock, reset high
`timescale 1ns/1ps
`default_nettype none
`include "plim_consts.svh"
module plim_link_chk
  import plim_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic p2d_vld,
  input wire plim_msg_t p2d_msg,
  input wire logic d2p_vld,
  input wire plim_msg_t d2p_msg
);
  // ***************
  // link properties
  // ***************
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  wire acc_out = d2p_vld && d2p_msg.op == OP_LS_ACC;
  wire acc_in = p2d_vld && p2d_msg.op == OP_LS_ACC;
  wire rjt_out = d2p_vld && d2p_msg.op inside {OP_LS_RJT, OP_LOGO};
  wire req_in = p2d_vld && !p2d_msg.lerr;
  wire [`PLIM_ID_W-1:0] req_src = p2d_msg.s_id;
  sequence s_refuse;
    ##1 rjt_out;
  endsequence
  sequence s_accept;
    ##1 !d2p_vld [*5] ##1 acc_out;
  endsequence
  prli_reply_a:
    assert property (req_in && p2d_msg.op == OP_PRLI |-> s_refuse or s_accept)
    else $error("prli reply");
  prlo_accept_a:
    assert property (req_in && p2d_msg.op == OP_PRLO |->
      ##2 acc_out && d2p_msg.d_id == $past(req_src, 2))
    else $error("prlo reply");
  reject_code_a:
    assert property (d2p_vld && d2p_msg.op == OP_LS_RJT |-> d2p_msg.rsn == `PLIM_RSN_UNABLE &&
      d2p_msg.expl inside {`PLIM_EXP_LOGIN, `PLIM_EXP_FULL}) else $error("reject code");
  reject_quiet_a:
    assert property (rjt_out |=> !d2p_vld [*2]) else $error("traffic after reject");
  abts_after_acc_a:
    assert property (d2p_vld && d2p_msg.op == OP_ABTS |-> $past(acc_out, 2) || $past(acc_in, 3))
    else $error("abort without accept");
  peer_accept_a:
    assert property (d2p_vld && d2p_msg.op inside {OP_PRLI, OP_PRLO} |=> acc_in)
    else $error("peer no accept");
  port_ack_a:
    assert property (p2d_vld && p2d_msg.op == OP_DATA |=> d2p_vld && d2p_msg.op == OP_ACK)
    else $error("port no ack");
  peer_ack_a:
    assert property (d2p_vld && d2p_msg.op == OP_DATA |=> p2d_vld && p2d_msg.op == OP_ACK)
    else $error("peer no ack");
endmodule
`default_nettype wire

// >>> sim/plim_tb_top.sv
// bench: port and peer ends on one link, compared with a table model
// assumes design files and plim_link_chk compiled first
`timescale 1ns/1ps
`default_nettype none
`include "plim_consts.svh"
module plim_tb_top;
  import plim_pkg::*;
  // ******************
  // stimulus and model
  // ******************
  logic clk = 1'b0, rst = 1'b1, lok = 1'b0, logo = 1'b0, qlg = 1'b0, pv = 1'b0, qv = 1'b0;
  logic tv = 1'b0, es = 1'b0;
  logic [7:0] ty = 8'h00, pa = 8'h00, b, pm, mt[4], mp[4];
  plim_op_t op = OP_NONE;
  logic pd, qd, ts, tb, iu, st, qi, qa, prdy, qrdy;
  plim_key_t ek;
  plim_res_t pr, qr;
  logic [`PLIM_TBL_DEPTH-1:0] est;
  int c[5], e[5], n_errors, samples_checked, seed, k;
  bit mv[4];
  wire plim_key_t pkey = {24'h00a100, 24'h00b200, ty};
  wire plim_key_t qkey = {24'h00b200, 24'h00a100, ty};
  plim_if plim_if_inst ();
  plim_port plim_port_inst (.CORE_CLK_I(clk), .RST_I(rst), .LINK(plim_if_inst), .LOGIN_OK_I(lok),
    .NOLOGIN_LOGO_I(logo), .CMD_VLD_I(pv), .CMD_OP_I(op), .CMD_KEY_I(pkey), .CMD_EST_I(es),
    .CMD_PARM_I(pa), .CMD_RDY_O(prdy), .CMD_DONE_O(pd), .CMD_RES_O(pr), .TX_VLD_I(tv),
    .TX_KEY_I(pkey), .TX_SENT_O(ts), .TX_BLK_O(tb), .RX_IU_O(iu), .RX_STRAY_O(st),
    .EVT_KEY_O(ek), .EST_O(est));
  plim_peer plim_peer_inst (.CORE_CLK_I(clk), .RST_I(rst), .LINK(plim_if_inst), .LOGIN_I(qlg),
    .CMD_VLD_I(qv), .CMD_OP_I(op), .CMD_KEY_I(qkey), .CMD_EST_I(es), .CMD_PARM_I(pa),
    .CMD_RDY_O(qrdy), .CMD_DONE_O(qd), .CMD_RES_O(qr), .RX_IU_O(qi), .RX_ABTS_O(qa));
  plim_link_chk plim_link_chk_inst (.CORE_CLK_I(clk), .RST_I(rst),
    .p2d_vld(plim_if_inst.p2d_vld), .p2d_msg(plim_if_inst.p2d_msg),
    .d2p_vld(plim_if_inst.d2p_vld), .d2p_msg(plim_if_inst.d2p_msg));
  always #5 clk = ~clk;
  // pulse counts: abort, rx unit, stray, blocked, peer rx unit
  always @(negedge clk) begin
    c[0] += int'(qa === 1'b1);
    c[1] += int'(iu === 1'b1);
    c[2] += int'(st === 1'b1);
    c[3] += int'(tb === 1'b1);
    c[4] += int'(qi === 1'b1);
  end
  function automatic int find(input logic [7:0] t);
    for (int i = 0; i < 4; i++)
      if (mv[i] && mt[i] === t) return i;
    return -1;
  endfunction
  function automatic plim_res_t m_prli(input logic [7:0] t, input logic bnd, input logic [7:0] p);
    int i;
    i = find(t);
    if (!lok) return RES_REJ;
    if (!bnd) return RES_OK;
    if (i >= 0) begin
      e[0] += int'(mp[i] !== p);
      mp[i] = p;
      return RES_OK;
    end
    for (i = 0; i < 4; i++)
      if (!mv[i]) begin
        mv[i] = 1'b1;
        mt[i] = t;
        mp[i] = p;
        return RES_OK;
      end
    return RES_REJ;
  endfunction
  function automatic plim_res_t m_prlo(input logic [7:0] t);
    int i;
    i = find(t);
    if (i >= 0) begin
      mv[i] = 1'b0;
      e[0]++;
    end
    return RES_OK;
  endfunction
  function automatic plim_res_t m_use(input logic [7:0] t, input int hit, input int miss);
    e[find(t) >= 0 ? hit : miss]++;
    return RES_OK;
  endfunction
  task automatic note(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      n_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, g, x);
    end
  endtask
  task automatic chk_res(input plim_res_t g, input plim_res_t x);
    note(32'(g), 32'(x));
  endtask
  task automatic chk_est(input logic [`PLIM_TBL_DEPTH-1:0] g, input logic [`PLIM_TBL_DEPTH-1:0] x);
    note(32'(g), 32'(x));
  endtask
  task automatic chk_cnt(input int g, input int x);
    note(32'(g), 32'(x));
  endtask
  task automatic chk_flag(input logic g, input logic x);
    note(32'(g), 32'(x));
  endtask
  task automatic chk_key(input plim_key_t g, input plim_key_t x);
    note(g[31:0], x[31:0]);
    note(32'(g[55:32]), 32'(x[55:32]));
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic await(input int w);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while ((w == 0 ? pd : w == 1 ? qd : ts | tb) !== 1'b1 && n < 1000);
    if (n >= 1000) begin
      n_errors++;
      complete_run;
    end
  endtask
  task automatic check_all;
    logic [`PLIM_TBL_DEPTH-1:0] x;
    repeat (4) @(posedge clk);
    @(negedge clk);
    for (int i = 0; i < 4; i++) x[i] = mv[i];
    chk_est(est, x);
    for (int i = 0; i < 5; i++) chk_cnt(c[i], e[i]);
  endtask
  task automatic cmd(input bit port, input plim_op_t o, input logic [7:0] t, input logic bnd,
                     input logic [7:0] p, input plim_res_t x);
    @(negedge clk);
    chk_flag(port ? prdy : qrdy, 1'b1);
    op = o;
    ty = t;
    es = bnd;
    pa = p;
    pv = port;
    qv = !port;
    await(port ? 0 : 1);
    chk_res(port ? pr : qr, x);
    @(negedge clk);
    pv = 1'b0;
    qv = 1'b0;
    check_all;
  endtask
  task automatic tx(input logic [7:0] t);
    void'(m_use(t, 4, 3));
    @(negedge clk);
    ty = t;
    tv = 1'b1;
    await(2);
    chk_key(ek, pkey);
    @(negedge clk);
    tv = 1'b0;
    check_all;
  endtask
  initial begin
    seed = 32'hf99b;
    b = 8'($random(seed));
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    cmd(0, OP_PRLI, b, 1'b1, 8'h00, RES_REFUSED);
    qlg = 1'b1;
    for (k = 0; k < 2; k++) begin
      logo = k[0];
      cmd(0, OP_PRLI, b, 1'b1, 8'h00, m_prli(b, 1'b1, 8'h00));
    end
    lok = 1'b1;
    cmd(0, OP_PRLI, b + 8'h09, 1'b0, 8'h00, m_prli(b + 8'h09, 1'b0, 8'h00));
    for (k = 0; k < 6; k++) begin
      pm = 8'($random(seed));
      cmd(0, OP_PRLI, b + 8'(k % 5), 1'b1, pm, m_prli(b + 8'(k % 5), 1'b1, pm));
    end
    for (k = 0; k < 2; k++)
      cmd(0, OP_DATA, b + 8'(9 * k), 1'b0, 8'h00, m_use(b + 8'(9 * k), 1, 2));
    for (k = 0; k < 2; k++)
      cmd(0, OP_PRLO, b, 1'b0, 8'h00, m_prlo(b));
    for (k = 0; k < 2; k++)
      tx(b + 8'(k));
    pm = 8'($random(seed));
    cmd(1, OP_PRLI, b, 1'b1, pm, m_prli(b, 1'b1, pm));
    cmd(1, OP_PRLO, b + 8'h01, 1'b0, 8'h00, m_prlo(b + 8'h01));
    complete_run;
  end
endmodule
`default_nettype wire
